// ===== common/tcs_pkg.sv
/*
 Package of the transmit control and status register block: offsets,
 bit positions, reset values and slot time.
 Assumes a 20 MHz system clock.
*/
`default_nettype none

package tcs_pkg;

   // ==========================================================
   // Register map
   localparam logic [5:0] TCS_REG_OFFSET = 6'h03;
   localparam logic [5:0] TCS_LINK_OFFSET = 6'h3f;

   // ==========================================================
   // Bit positions
   localparam int PROG_INT_BIT = 15;
   localparam int LATE_SEL_BIT = 14;
   localparam int CRC_INH_BIT = 13;
   localparam int EXDEF_DIS_BIT = 12;
   localparam int EXDEF_BIT = 10;
   localparam int DEFER_BIT = 9;
   localparam int NOCRS_BIT = 8;
   localparam int CRSLOST_BIT = 7;
   localparam int EXCOL_BIT = 6;
   localparam int LATECOL_BIT = 5;
   localparam int MONBAD_BIT = 3;
   localparam int UNDERRUN_BIT = 2;
   localparam int BCMISS_BIT = 1;
   localparam int SENTOK_BIT = 0;

   // ==========================================================
   // Masks and reset value
   localparam logic [15:0] MODE_MASK = 16'hf000;
   localparam logic [15:0] STATUS_MASK = 16'h07ef;
   localparam logic [15:0] WB_CLEAR_MASK = 16'h0220;
   localparam logic [15:0] START_CLEAR_MASK = 16'h04c2;
   localparam logic [15:0] HW_RESET_VALUE = 16'h0101;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOT_TIME_NS = 51_200;
   localparam int SLOT_CYCLES = (SLOT_TIME_NS / 50);
   localparam int MAX_COLLISIONS = 16;
   localparam int COLL_W = 5;

endpackage : tcs_pkg

`default_nettype wire

// ===== hdl/tcs_slot_timer.sv
/*
 Slot timer: counts cycles from a chosen start point of the frame and
 flags when one slot time has passed.
 Assumes start pulses come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module tcs_slot_timer
#(
   parameter int SLOT_CYCLES = tcs_pkg::SLOT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic stop_i,
   output logic expired_o
);

   logic [11:0] count_reg;
   logic [11:0] count_next;
   logic run_reg;
   logic run_next;
   logic expired_reg;
   logic expired_next;

   // ==========================================================
   // Counter next state
   always_comb
   begin
      count_next = count_reg;
      run_next = run_reg;
      expired_next = expired_reg;
      if (stop_i)
      begin
         run_next = 1'b0;
         expired_next = 1'b0;
      end
      else if (start_i)
      begin
         run_next = 1'b1;
         expired_next = 1'b0;
         count_next = 12'h0000;
      end
      else if (run_reg)
      begin
         if (count_reg == 12'(SLOT_CYCLES - 1))
         begin
            run_next = 1'b0;
            expired_next = 1'b1;
         end
         else
         begin
            count_next = count_reg + 12'h0001;
         end
      end
   end

   // Counter registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         count_reg <= 12'h0000;
         run_reg <= 1'b0;
         expired_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         run_reg <= run_next;
         expired_reg <= expired_next;
      end
   end

   assign expired_o = expired_reg;

endmodule : tcs_slot_timer

`default_nettype wire

// ===== hdl/tcs_transmit_control_status.sv
/*
 Transmit control and status register of the transmit unit. Latches
 mode bits at frame start, gathers per-frame status, builds the
 descriptor status word and applies write-back and start clears.
 Assumes frame events are single-cycle pulses on clk_i, and the link
 level inputs carrier_sense_i and collision_i come from pins.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module tcs_transmit_control_status
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic soft_reset_i,
   input wire logic [5:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic tx_start_i,
   input wire logic [15:0] descriptor_config_word_i,
   input wire logic sfd_sent_i,
   input wire logic tx_end_i,
   input wire logic deferred_i,
   input wire logic excess_deferral_i,
   input wire logic monitored_bad_i,
   input wire logic byte_count_mismatch_i,
   input wire logic fifo_empty_i,
   input wire logic bus_granted_i,
   input wire logic carrier_sense_i,
   input wire logic collision_i,
   input wire logic status_written_i,
   output logic [15:0] descriptor_status_word_o,
   output logic status_write_o,
   output logic tx_abort_o,
   output logic append_fcs_o
);

   // ==========================================================
   // Pin synchronisers
   logic crs_meta_reg;
   logic crs_sync_reg;
   logic col_meta_reg;
   logic col_sync_reg;
   logic col_last_reg;
   logic col_edge;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         crs_meta_reg <= 1'b0;
         crs_sync_reg <= 1'b0;
         col_meta_reg <= 1'b0;
         col_sync_reg <= 1'b0;
         col_last_reg <= 1'b0;
      end
      else
      begin
         crs_meta_reg <= carrier_sense_i;
         crs_sync_reg <= crs_meta_reg;
         col_meta_reg <= collision_i;
         col_sync_reg <= col_meta_reg;
         col_last_reg <= col_sync_reg;
      end
   end

   // Collision start, one pulse per collision
   assign col_edge = col_sync_reg & ~col_last_reg;

   // ==========================================================
   // Late collision slot timer
   logic slot_expired;
   logic timer_start;
   logic [15:0] tcs_reg;

   // Select set: count from preamble, clear: from delimiter, new at start
   assign timer_start =
      (tx_start_i & descriptor_config_word_i[tcs_pkg::LATE_SEL_BIT])
      | (sfd_sent_i & ~tcs_reg[tcs_pkg::LATE_SEL_BIT]);

   tcs_slot_timer #(.SLOT_CYCLES(tcs_pkg::SLOT_CYCLES)) u_slot
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(timer_start),
      .stop_i(tx_end_i),
      .expired_o(slot_expired)
   );

   // ==========================================================
   // Register state
   logic [15:0] tcs_next;
   logic [4:0] coll_reg;
   logic [4:0] coll_next;
   logic active_reg;
   logic active_next;
   logic abort_reg;
   logic abort_next;
   logic crs_seen_reg;
   logic crs_seen_next;
   logic crs_lost_reg;
   logic crs_lost_next;
   logic after_sfd_reg;
   logic after_sfd_next;
   logic [15:0] status_word_reg;
   logic [15:0] status_word_next;
   logic status_write_reg;
   logic status_write_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   // Status update, mode latch and clears
   always_comb
   begin
      tcs_next = tcs_reg;
      coll_next = coll_reg;
      active_next = active_reg;
      abort_next = 1'b0;
      crs_seen_next = crs_seen_reg;
      crs_lost_next = crs_lost_reg;
      after_sfd_next = after_sfd_reg;
      status_word_next = status_word_reg;
      status_write_next = 1'b0;
      // Soft reset leaves all bits alone
      if (soft_reset_i)
      begin
         tcs_next = tcs_reg;
      end
      // Host writes reach the mode bits only
      if (wr_i && addr_i == tcs_pkg::TCS_REG_OFFSET)
      begin
         tcs_next = (tcs_reg & ~tcs_pkg::MODE_MASK)
                    | (wdata_i & tcs_pkg::MODE_MASK);
      end
      // Write-back done
      if (status_written_i)
      begin
         tcs_next = tcs_next & ~tcs_pkg::WB_CLEAR_MASK;
      end
      if (tx_start_i)
      begin
         tcs_next = (tcs_next & ~tcs_pkg::MODE_MASK)
                    | (descriptor_config_word_i & tcs_pkg::MODE_MASK);
         tcs_next = tcs_next & ~tcs_pkg::START_CLEAR_MASK;
         tcs_next[tcs_pkg::UNDERRUN_BIT] = 1'b0;
         tcs_next[tcs_pkg::NOCRS_BIT] = 1'b1;
         coll_next = 5'h00;
         active_next = 1'b1;
         crs_seen_next = 1'b0;
         crs_lost_next = 1'b0;
         after_sfd_next = 1'b0;
      end
      else if (active_reg)
      begin
         if (sfd_sent_i)
         begin
            after_sfd_next = 1'b1;
         end
         // Carrier watched from the delimiter to the last byte
         if (after_sfd_reg || sfd_sent_i)
         begin
            if (crs_sync_reg)
            begin
               crs_seen_next = 1'b1;
               tcs_next[tcs_pkg::NOCRS_BIT] = 1'b0;
            end
            else
            begin
               crs_lost_next = 1'b1;
            end
         end
         if (deferred_i)
         begin
            tcs_next[tcs_pkg::DEFER_BIT] = 1'b1;
         end
         if (excess_deferral_i && !tcs_reg[tcs_pkg::EXDEF_DIS_BIT])
         begin
            tcs_next[tcs_pkg::EXDEF_BIT] = 1'b1;
            abort_next = 1'b1;
         end
         if (col_edge)
         begin
            coll_next = coll_reg + 5'h01;
            // Later collisions undo the deferral indication
            tcs_next[tcs_pkg::DEFER_BIT] = 1'b0;
            if (slot_expired)
            begin
               tcs_next[tcs_pkg::LATECOL_BIT] = 1'b1;
            end
            if (coll_reg == 5'(tcs_pkg::MAX_COLLISIONS - 1))
            begin
               tcs_next[tcs_pkg::EXCOL_BIT] = 1'b1;
               abort_next = 1'b1;
            end
         end
         if (fifo_empty_i && !bus_granted_i)
         begin
            tcs_next[tcs_pkg::UNDERRUN_BIT] = 1'b1;
            abort_next = 1'b1;
         end
         if (tx_end_i)
         begin
            active_next = 1'b0;
            // Monitoring is meaningless with CRC inhibited
            tcs_next[tcs_pkg::MONBAD_BIT] = monitored_bad_i
               & ~tcs_reg[tcs_pkg::CRC_INH_BIT];
            tcs_next[tcs_pkg::BCMISS_BIT] = byte_count_mismatch_i;
            tcs_next[tcs_pkg::CRSLOST_BIT] = crs_lost_reg | ~crs_seen_reg;
            tcs_next[tcs_pkg::SENTOK_BIT] =
               ~(tcs_next[tcs_pkg::EXCOL_BIT]
                 | tcs_next[tcs_pkg::UNDERRUN_BIT]
                 | tcs_next[tcs_pkg::EXDEF_BIT]
                 | byte_count_mismatch_i);
            status_word_next = {coll_next[3:0], 1'b0,
               tcs_next[10:0] & tcs_pkg::STATUS_MASK[10:0]};
            status_write_next = 1'b1;
         end
      end
      // Read data one cycle later, unmapped reads as zero
      rdata_next = 16'h0000;
      if (rd_i && addr_i == tcs_pkg::TCS_REG_OFFSET)
      begin
         rdata_next = tcs_reg & (tcs_pkg::MODE_MASK | tcs_pkg::STATUS_MASK);
      end
   end

   // Registers, hardware reset value
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tcs_reg <= tcs_pkg::HW_RESET_VALUE;
         coll_reg <= 5'h00;
         active_reg <= 1'b0;
         abort_reg <= 1'b0;
         crs_seen_reg <= 1'b0;
         crs_lost_reg <= 1'b0;
         after_sfd_reg <= 1'b0;
         status_word_reg <= 16'h0000;
         status_write_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         tcs_reg <= tcs_next;
         coll_reg <= coll_next;
         active_reg <= active_next;
         abort_reg <= abort_next;
         crs_seen_reg <= crs_seen_next;
         crs_lost_reg <= crs_lost_next;
         after_sfd_reg <= after_sfd_next;
         status_word_reg <= status_word_next;
         status_write_reg <= status_write_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata_o = rdata_reg;
   assign descriptor_status_word_o = status_word_reg;
   assign status_write_o = status_write_reg;
   assign tx_abort_o = abort_reg;
   assign append_fcs_o = ~tcs_reg[tcs_pkg::CRC_INH_BIT];

   // ==========================================================
   // Checks
   chk_start_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_start_i |=> tcs_reg[15:12] == $past(descriptor_config_word_i[15:12]))
      else $error("mode bits not latched");
   chk_start_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_start_i |=> tcs_reg[8] && !tcs_reg[10] && !tcs_reg[7]
                     && !tcs_reg[6] && !tcs_reg[1])
      else $error("start clear wrong");
   chk_wb_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_written_i && !tx_start_i && !active_reg
      |=> !tcs_reg[9] && !tcs_reg[5])
      else $error("write-back clear missing");
   chk_end_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      active_reg && tx_end_i && !tx_start_i |=> status_write_o
      ##1 !status_write_o)
      else $error("status write missing");
   chk_word_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_write_o |-> descriptor_status_word_o[10:0]
                         == (tcs_reg[10:0] & 11'h7ef))
      else $error("status word mismatch");
   chk_fcs_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      append_fcs_o != tcs_reg[13])
      else $error("fcs append wrong");
   chk_underrun_abort: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      active_reg && !tx_start_i && fifo_empty_i && !bus_granted_i
      |=> tx_abort_o && tcs_reg[2])
      else $error("underrun not flagged");
   chk_hold_soft: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      soft_reset_i && !active_reg && !tx_start_i && !wr_i
      && !status_written_i |=> $stable(tcs_reg))
      else $error("soft reset altered reg");
   chk_excess_coll: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      active_reg && !tx_start_i && col_edge && coll_reg == 5'h0f
      |=> tx_abort_o && tcs_reg[6])
      else $error("sixteenth collision missed");

endmodule : tcs_transmit_control_status

`default_nettype wire

// ===== tb/tcs_host_model.sv
/*
 Host and descriptor memory model: stores each descriptor status word
 and reports it written back after a chosen number of cycles.
 Assumes status_write_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module tcs_host_model
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] delay_i,
   input wire logic status_write_i,
   input wire logic [15:0] status_word_i,
   output logic [15:0] stored_word_o,
   output logic status_written_o
);
   // ==========================================================
   // Store the word, wait, then pulse written back
   int cnt;
   always @(posedge clk_i)
   begin
      status_written_o <= 1'b0;
      if (!rst_n_i)
      begin
         cnt <= 0;
         stored_word_o <= 16'h0000;
      end
      else if (status_write_i)
      begin
         stored_word_o <= status_word_i;
         cnt <= int'(delay_i) + 1;
      end
      else if (cnt > 0)
      begin
         cnt <= cnt - 1;
         status_written_o <= (cnt == 1);
      end
   end
endmodule : tcs_host_model

`default_nettype wire

// ===== tb/tb_top.sv
/*
 Testbench of the transmit control and status block: register port,
 frame events and descriptor write-back against the host model.
 Assumes the register sits at offset 0x03 and a 50 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clk, rst_n, soft_rst, wr, rd, start, sfd, tx_end, def, excessive_deferral_flag;
   logic mb, byte_count_mismatch_flag, fifo_empty, granted, crs, col, written, swr, abort, fcs;
   logic [5:0] addr;
   logic [15:0] wdata, rdata, cfg, word, stored, exp_reg, rv, r;
   logic [3:0] delay;
   logic [31:0] seed;
   int miscompares, compares, aborts, wdone, i;

   tcs_transmit_control_status u_tcs_transmit_control_status
   (
      .clk_i(clk), .rst_n_i(rst_n), .soft_reset_i(soft_rst),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .tx_start_i(start),
      .descriptor_config_word_i(cfg), .sfd_sent_i(sfd),
      .tx_end_i(tx_end), .deferred_i(def), .excess_deferral_i(excessive_deferral_flag),
      .monitored_bad_i(mb), .byte_count_mismatch_i(byte_count_mismatch_flag),
      .fifo_empty_i(fifo_empty), .bus_granted_i(granted),
      .carrier_sense_i(crs), .collision_i(col),
      .status_written_i(written), .descriptor_status_word_o(word),
      .status_write_o(swr), .tx_abort_o(abort), .append_fcs_o(fcs)
   );

   tcs_host_model u_tcs_host_model
   (
      .clk_i(clk), .rst_n_i(rst_n), .delay_i(delay),
      .status_write_i(swr), .status_word_i(word),
      .stored_word_o(stored), .status_written_o(written)
   );

   // ==========================================================
   // Clock, event counters and watchdog
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (abort === 1'b1) aborts <= aborts + 1;
      if (written === 1'b1) wdone <= wdone + 1;
   end

   initial
   begin
      #1_000_000;
      miscompares++;
      finish_test();
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Expected status word; kind 1 sixteen collisions, 2 late, 3 underrun
   function automatic logic [15:0] exp_status(input logic [15:0] c,
      input int kind, input logic cs, ex, bad, bc);
      logic [15:0] w;
      w = 16'h0000;
      w[15:12] = (kind == 2) ? 4'h1 : 4'h0;
      w[10] = ex & ~c[12];
      w[9] = (kind == 0);
      w[8] = ~cs;
      w[7] = ~cs;
      w[6] = (kind == 1);
      w[5] = (kind == 2);
      w[3] = bad & ~c[13];
      w[2] = (kind == 3);
      w[1] = bc;
      w[0] = ~(w[10] | w[6] | w[2]) & ~bc;
      return w;
   endfunction : exp_status

   task check_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: word %h not %h", $time, got, exp);
      end
   endtask : check_word

   task check_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: flag %b not %b", $time, got, exp);
      end
   endtask : check_bit

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task bus_write(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_write

   task bus_read(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : bus_read

   // One frame from start to descriptor write-back
   task frame(input logic [15:0] c, input int kind,
      input logic cs, ex, bad, bc);
      logic [15:0] w, q;
      int n0, w0, k;
      w = exp_status(c, kind, cs, ex, bad, bc);
      @(posedge clk);
      start <= 1'b1;
      cfg <= c;
      crs <= cs;
      @(posedge clk);
      start <= 1'b0;
      cyc(2);
      // Start clears 10, 7, 6, 1 and the per-frame underrun, sets 8
      exp_reg = {c[15:12], 1'b0, (exp_reg[10:0] & ~11'h4c6) | 11'h100};
      bus_read(6'h03, q);
      check_word(q, exp_reg);
      check_bit(fcs, ~c[13]);
      n0 = aborts;
      w0 = wdone;
      @(posedge clk);
      sfd <= 1'b1;
      def <= (kind == 0);
      excessive_deferral_flag <= ex;
      @(posedge clk);
      sfd <= 1'b0;
      def <= 1'b0;
      excessive_deferral_flag <= 1'b0;
      for (k = 0; k < ((kind == 1) ? 16 : (kind == 2)); k++)
      begin
         if (kind == 2) cyc(1100);
         col <= 1'b1;
         cyc(3);
         col <= 1'b0;
         cyc(3);
      end
      fifo_empty <= (kind == 3);
      granted <= (kind != 3);
      mb <= bad;
      byte_count_mismatch_flag <= bc;
      cyc(4);
      fifo_empty <= 1'b0;
      granted <= 1'b1;
      tx_end <= 1'b1;
      @(posedge clk);
      tx_end <= 1'b0;
      for (k = 0; k < 40 && wdone == w0; k++) @(negedge clk);
      check_word(stored, w);
      check_bit(aborts != n0, w[10] | w[6] | w[2]);
      exp_reg[10:0] = w[10:0] & ~11'h220;
      bus_read(6'h03, q);
      check_word(q, exp_reg);
      crs <= 1'b0;
      mb <= 1'b0;
      byte_count_mismatch_flag <= 1'b0;
   endtask : frame

   task finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // ==========================================================
   // Main sequence
   initial
   begin
      {rst_n, soft_rst, wr, rd, start, sfd, tx_end, def, excessive_deferral_flag} = '0;
      {mb, byte_count_mismatch_flag, fifo_empty, crs, col} = '0;
      granted = 1'b1;
      addr = 6'h00;
      wdata = 16'h0000;
      cfg = 16'h0000;
      delay = 4'h0;
      seed = 32'h0001_0c16;
      miscompares = 0;
      compares = 0;
      aborts = 0;
      wdone = 0;
      cyc(2);
      rst_n <= 1'b1;
      bus_read(6'h03, r);
      check_word(r, 16'h0101);
      bus_write(6'h03, 16'hffff);
      exp_reg = 16'hf101;
      bus_write(6'h05, 16'h0000);
      bus_read(6'h05, r);
      check_word(r, 16'h0000);
      soft_rst <= 1'b1;
      cyc(3);
      soft_rst <= 1'b0;
      bus_read(6'h03, r);
      check_word(r, exp_reg);
      frame(16'h0000, 1, 1'b1, 1'b0, 1'b0, 1'b0);
      frame(16'h4000, 2, 1'b1, 1'b0, 1'b0, 1'b0);
      frame(16'h8000, 2, 1'b1, 1'b0, 1'b0, 1'b0);
      frame(16'h2000, 3, 1'b1, 1'b0, 1'b1, 1'b0);
      frame(16'h0000, 0, 1'b0, 1'b1, 1'b1, 1'b1);
      for (i = 0; i < 12; i++)
      begin
         rv = 16'(rnd());
         delay <= rv[11:8];
         frame(rv, 0, rv[4], rv[5], rv[6], rv[7]);
      end
      soft_rst <= 1'b1;
      cyc(2);
      soft_rst <= 1'b0;
      bus_read(6'h03, r);
      check_word(r, exp_reg);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      bus_read(6'h03, r);
      check_word(r, 16'h0101);
      finish_test();
   end
endmodule : tb_top

`default_nettype wire
